// ===== design/slw_core.sv
// Purpose: Control of a synchronous late-write, pipelined-read SRAM.
// Assumes: The controller runs on clk_i, so its outputs need no synchroniser.
// Notes: The echo clock is modelled as a register toggling on every rising edge of clk_i.
`timescale 1ns/10ps
module slw_core
    import slw_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Command inputs
    input  wire logic [`SLW_ADDR_W-1:0] address_i,
    input  wire logic                   advance_load_i,
    input  wire logic                   write_n_i,
    input  wire logic [`SLW_LANES-1:0]  byte_lane_we_n_i,
    // Selects
    input  wire logic                   primary_select_n_i,
    input  wire logic [1:0]             programmable_selects_i,
    // Static straps
    input  wire logic [1:0]             select_polarity_straps_i,
    input  wire logic                   drive_strength_strap_i,
    // Data pins
    input  wire logic [`SLW_DATA_W-1:0] dq_i,
    output logic      [`SLW_DATA_W-1:0] dq_o,
    output logic                        dq_oe_o,
    // Echo clocks
    output logic                        echo_clk_o,
    output logic                        echo_clk_n_o,
    output logic                        echo_clk_oe_o,
    // Drive strength
    output logic                        high_drive_o
);
    slw_mem_if mem_bus ();

    slw_mem slw_mem_inst (
        .clk_i (clk_i),
        .bus   (mem_bus)
    );

    // Command state.
    slw_op_t    op;
    slw_op_t    next_op;
    slw_addr_t  base_addr;
    logic [`SLW_BURST_W-1:0] burst_cnt;
    logic [`SLW_BURST_W-1:0] next_cnt;
    slw_addr_t  access_addr;

    // Pipeline state.
    logic       rd_pend;
    logic       wr_pend;
    slw_addr_t  wr_addr;
    slw_lanes_t wr_lanes;

    // Decoded inputs.
    logic       bank_true;
    logic       active;
    logic       load;
    logic       advance;
    logic       start_read;
    logic       start_write;
    logic       bank_desel;
    logic       desel;
    logic       do_read;
    logic       do_write;

    // A programmable select counts as true when it matches its strap level.
    assign bank_true   = (programmable_selects_i == select_polarity_straps_i);
    assign active      = !primary_select_n_i && bank_true;
    assign load        = !advance_load_i;
    assign advance     = advance_load_i;
    assign start_read  = load && active && write_n_i;
    assign start_write = load && active && !write_n_i;
    assign bank_desel  = load && !bank_true;
    assign desel       = load && bank_true && primary_select_n_i;

    // Burst beats inherit the type of the loading command.
    assign do_read  = start_read || (advance && op == SLW_OP_READ);
    assign do_write = start_write || (advance && op == SLW_OP_WRITE);

    always_comb begin
        next_op = op;
        case (1'b1)
            bank_desel:  next_op = SLW_OP_BANK_DESEL;
            desel:       next_op = SLW_OP_DESEL;
            start_read:  next_op = SLW_OP_READ;
            start_write: next_op = SLW_OP_WRITE;
            default:     next_op = op;
        endcase
    end

    // The counter wraps naturally in two bits, returning to the base after four.
    always_comb begin
        next_cnt = burst_cnt;
        if (load) begin
            next_cnt = `SLW_RST_CNT;
        end else begin
            next_cnt = burst_cnt + 2'h1;
        end
    end

    always_comb begin
        if (load) begin
            access_addr = address_i;
        end else begin
            access_addr = {base_addr[`SLW_ADDR_W-1:`SLW_BURST_W],
                           base_addr[`SLW_BURST_W-1:0] + next_cnt};
        end
    end

    // Operation type.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op <= SLW_OP_BANK_DESEL;
        end else begin
            op <= next_op;
        end
    end

    // Burst address generator; the base is loaded even by an aborted write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            base_addr <= `SLW_RST_ADDR;
            burst_cnt <= `SLW_RST_CNT;
        end else if (load && active) begin
            base_addr <= address_i;
            burst_cnt <= `SLW_RST_CNT;
        end else if (advance) begin
            burst_cnt <= next_cnt;
        end
    end

    // Late write: lanes are taken with the command, data one edge later.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_pend  <= 1'b0;
            wr_addr  <= `SLW_RST_ADDR;
            wr_lanes <= `SLW_NO_LANES;
        end else begin
            wr_pend  <= do_write;
            wr_addr  <= access_addr;
            wr_lanes <= do_write ? ~byte_lane_we_n_i : `SLW_NO_LANES;
        end
    end

    // Read pipeline marker for the output register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_pend <= 1'b0;
        end else begin
            rd_pend <= do_read;
        end
    end

    assign mem_bus.rd_en    = do_read;
    assign mem_bus.rd_addr  = access_addr;
    assign mem_bus.wr_en    = wr_pend;
    assign mem_bus.wr_addr  = wr_addr;
    assign mem_bus.wr_lanes = wr_lanes;
    assign mem_bus.wr_data  = dq_i;

    // Output register: read word goes out one edge after the command.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dq_o <= `SLW_RST_DATA;
        end else if (rd_pend) begin
            dq_o <= mem_bus.rd_data;
        end
    end

    // Data pins float after a deselect or write; they drive only read beats.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dq_oe_o <= 1'b0;
        end else begin
            dq_oe_o <= rd_pend;
        end
    end

    // Echo clock enable follows the registered bank state, so it takes the same two
    // flops as the read data and never floats a cycle ahead of the data pins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            echo_clk_oe_o <= 1'b0;
        end else begin
            echo_clk_oe_o <= (op != SLW_OP_BANK_DESEL);
        end
    end

    // Both echo phases come from flops so they switch with the data register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            echo_clk_o   <= 1'b0;
            echo_clk_n_o <= 1'b1;
        end else begin
            echo_clk_o   <= ~echo_clk_o;
            echo_clk_n_o <= echo_clk_o;
        end
    end

    // The strap is static; registering it only keeps the output on a flop.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_drive_o <= 1'b0;
        end else begin
            high_drive_o <= !drive_strength_strap_i;
        end
    end
endmodule

// ===== design/slw_regs.svh
// Purpose: Constants of the late-write pipelined-read SRAM core.
// Assumes: 36-bit organisation, four 9-bit byte lanes, one clock.
// Notes: Included by its bare name; definitions only.
// Summary of operation
// - Address, data and control are sampled on the rising clock edge; straps are static.
// - Device active only with primary and both programmable selects asserted.
// - Echo clocks float only on a programmable-select deselect, not primary-select.
// - Active selects, write enable high, advance_load low: latch address, start read.
// - Read data is driven onto the data pins one edge after the command.
// - Active selects, write enable low, advance_load low: latch address, start write.
// - Write data arrives and is captured one edge after the write command.
// - Each active-low byte lane enable decides whether its byte is written.
// - A write with no lane enabled is an abort: address loads, memory unchanged.
// - Four lane enables control four lanes; reads ignore the lane enables.
// - Advance_load high steps the burst counter and uses the counter address.
// - Burst counts linearly in the two low address bits, modulo four.
// - After four accesses the next advance wraps back to the loaded address.
// - True and inverted echo clocks switch together with the data drivers.
// - Echo clock disable after a bank deselect has the read data latency.
// - Each programmable select is active at the level of its polarity strap.
// - Drive strap low selects high drive, high selects low drive.
// - Data pins float one cycle after a bank deselect, deselect or write command.
`ifndef SLW_REGS_SVH
`define SLW_REGS_SVH
`define SLW_ADDR_W      19
`define SLW_DATA_W      36
`define SLW_LANES       4
`define SLW_LANE_W      9
`define SLW_BURST_W     2
`define SLW_RST_ADDR    19'h0_0000
`define SLW_RST_DATA    36'h0_0000_0000
`define SLW_RST_CNT     2'h0
`define SLW_NO_LANES    4'h0
`endif

// ===== design/slw_pkg.sv
// Purpose: Types shared by the SRAM core modules.
// Assumes: Constants come from slw_regs.svh.
// Notes: Operation type held across burst beats.
`include "slw_regs.svh"
package slw_pkg;
    typedef logic [`SLW_ADDR_W-1:0] slw_addr_t;
    typedef logic [`SLW_DATA_W-1:0] slw_data_t;
    typedef logic [`SLW_LANES-1:0]  slw_lanes_t;
    typedef enum logic [1:0] {
        SLW_OP_BANK_DESEL,
        SLW_OP_DESEL,
        SLW_OP_READ,
        SLW_OP_WRITE
    } slw_op_t;
endpackage

// ===== design/slw_mem_if.sv
// Purpose: Carries core requests to the storage array and its read word back.
// Assumes: One clock; all signals are sampled on its rising edge.
// Notes: Read and write may share a cycle.
`timescale 1ns/10ps
interface slw_mem_if;
    import slw_pkg::*;
    logic       rd_en;
    slw_addr_t  rd_addr;
    logic       wr_en;
    slw_addr_t  wr_addr;
    slw_lanes_t wr_lanes;
    slw_data_t  wr_data;
    slw_data_t  rd_data;
    modport core (output rd_en, rd_addr, wr_en, wr_addr, wr_lanes, wr_data, input rd_data);
    modport mem  (input rd_en, rd_addr, wr_en, wr_addr, wr_lanes, wr_data, output rd_data);
endinterface

// ===== design/slw_mem.sv
// Purpose: Storage array with per-lane writes and a synchronous read.
// Assumes: A read and a write of one address in one cycle see the new lanes.
// Notes: The bypass keeps a read just behind a late write coherent.
`timescale 1ns/10ps
module slw_mem
    import slw_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Core side
    slw_mem_if.mem   bus
);
    slw_data_t store [0:(1<<`SLW_ADDR_W)-1];
    slw_data_t merged;

    always_comb begin
        merged = store[bus.rd_addr];
        for (int i = 0; i < `SLW_LANES; i++) begin
            if (bus.wr_en && bus.wr_lanes[i] && bus.wr_addr == bus.rd_addr) begin
                merged[i*`SLW_LANE_W +: `SLW_LANE_W] = bus.wr_data[i*`SLW_LANE_W +: `SLW_LANE_W];
            end
        end
    end

    // Lanes whose enable is clear keep their contents, so an abort stores nothing.
    always_ff @(posedge clk_i) begin
        if (bus.wr_en) begin
            for (int i = 0; i < `SLW_LANES; i++) begin
                if (bus.wr_lanes[i]) begin
                    store[bus.wr_addr][i*`SLW_LANE_W +: `SLW_LANE_W] <=
                        bus.wr_data[i*`SLW_LANE_W +: `SLW_LANE_W];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (bus.rd_en) begin
            bus.rd_data <= merged;
        end
    end
endmodule

// ===== sim/slw_ctrl_model.sv
// Purpose: Controller side that returns late write data.
// Assumes: The bench hands data over together with the write beat.
// Notes: Idle lines show the inverse, so stale data never passes.
`timescale 1ns/10ps
module slw_ctrl_model
    import slw_pkg::*;
(
    // Clock
    input  wire logic      clk_i,
    // Bench request
    input  wire logic      send_i,
    input  wire slw_data_t data_i,
    // Data pins
    output slw_data_t      dq_o
);
    always_ff @(posedge clk_i) begin
        dq_o <= send_i ? data_i : ~dq_o;
    end
endmodule

// ===== sim/slw_core_monitor.sv
// Purpose: Port checks of the SRAM core.
// Assumes: One clock; synchronous reset.
// Notes: Echo enable checks hold the data latency exactly, early and late alike.
`timescale 1ns/10ps
module slw_core_monitor (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // Commands and straps
    input wire logic       advance_load_i,
    input wire logic       write_n_i,
    input wire logic       primary_select_n_i,
    input wire logic [1:0] programmable_selects_i,
    input wire logic [1:0] select_polarity_straps_i,
    input wire logic       drive_strength_strap_i,
    // Outputs
    input wire logic       dq_oe_o,
    input wire logic       echo_clk_o,
    input wire logic       echo_clk_n_o,
    input wire logic       echo_clk_oe_o,
    input wire logic       high_drive_o
);
    logic ld;
    logic bk;
    logic act;
    assign ld  = !advance_load_i;
    assign bk  = programmable_selects_i != select_polarity_straps_i;
    assign act = !primary_select_n_i && !bk;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_read_drives: assert property (ld && act && write_n_i |-> ##2 dq_oe_o)
        else $error("read not driven");
    chk_write_floats: assert property (ld && act && !write_n_i |-> ##2 !dq_oe_o)
        else $error("driven after write");
    chk_desel_floats: assert property (ld && !act |-> ##2 !dq_oe_o)
        else $error("driven after deselect");
    chk_read_continues: assert property (ld && act && write_n_i ##1 !ld |-> ##2 dq_oe_o)
        else $error("burst read beat lost");
    chk_write_continues: assert property (ld && act && !write_n_i ##1 !ld |-> ##2 !dq_oe_o)
        else $error("burst write beat drove");
    chk_bank_echo_off: assert property (ld && bk |-> ##2 !echo_clk_oe_o)
        else $error("echo on after bank deselect");
    chk_echo_lags_data: assert property (ld && !bk ##1 ld && bk |=> echo_clk_oe_o)
        else $error("echo disabled before data latency");
    chk_primary_echo_on: assert property (ld && !bk && primary_select_n_i ##1 !ld
        |=> echo_clk_oe_o) else $error("echo off after deselect");
    chk_echo_inverse: assert property (echo_clk_n_o == !echo_clk_o)
        else $error("echo pair not inverse");
    chk_echo_toggles: assert property (!$past(rst_i) |=> echo_clk_o != $past(echo_clk_o))
        else $error("echo clock stuck");
    chk_drive_strap: assert property ($stable(drive_strength_strap_i) && !$past(rst_i)
        |-> high_drive_o == !drive_strength_strap_i) else $error("drive strength wrong");
    cov_read: cover property (ld && act && write_n_i);
    cov_write: cover property (ld && act && !write_n_i);
    cov_bank: cover property (ld && bk ##1 !ld);
endmodule
bind slw_core slw_core_monitor slw_core_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
    .advance_load_i(advance_load_i), .write_n_i(write_n_i),
    .primary_select_n_i(primary_select_n_i), .programmable_selects_i(programmable_selects_i),
    .select_polarity_straps_i(select_polarity_straps_i),
    .drive_strength_strap_i(drive_strength_strap_i), .dq_oe_o(dq_oe_o), .echo_clk_o(echo_clk_o),
    .echo_clk_n_o(echo_clk_n_o), .echo_clk_oe_o(echo_clk_oe_o), .high_drive_o(high_drive_o));

// ===== sim/slw_core_bench.sv
// Purpose: Directed bench for the late-write SRAM core.
// Assumes: Inputs change on the falling edge only.
// Notes: A read is judged two commands later, the depth of the pipeline.
`timescale 1ns/10ps
module slw_core_bench
    import slw_pkg::*;
;
    localparam slw_addr_t  ad_a = 19'h0_1234;
    localparam slw_addr_t  ad_b = 19'h1_2346;
    localparam slw_data_t  d_p  = 36'h5_5555_5555;
    localparam slw_data_t  d_a  = 36'h0_0345_67FF;
    localparam logic [4:0] on   = 5'h00;
    logic       clk_i = 1'b0, rst_i = 1'b1, advance_load = 1'b0, wn = 1'b1, send = 1'b0, dstrap = 1'b0;
    logic [4:0] ctl   = 5'h10;
    slw_addr_t  addr  = '0;
    slw_lanes_t lanes = '0;
    slw_data_t  wdata = '0, dq_in, dq_out;
    logic       dq_oe, eck_oe, hdrv;
    int         errors = 0, cmp_count = 0, cycles = 0;
    int         pk [2] = '{0, 0};
    slw_data_t  pe [2];
    slw_core slw_core_inst (.clk_i(clk_i), .rst_i(rst_i), .address_i(addr),
        .advance_load_i(advance_load), .write_n_i(wn), .byte_lane_we_n_i(lanes),
        .primary_select_n_i(ctl[4]), .programmable_selects_i(ctl[1:0]),
        .select_polarity_straps_i(ctl[3:2]), .drive_strength_strap_i(dstrap), .dq_i(dq_in),
        .dq_o(dq_out), .dq_oe_o(dq_oe), .echo_clk_o(), .echo_clk_n_o(), .echo_clk_oe_o(eck_oe),
        .high_drive_o(hdrv));
    slw_ctrl_model slw_ctrl_model_inst (.clk_i(clk_i), .send_i(send), .data_i(wdata),
        .dq_o(dq_in));
    always #25 clk_i = ~clk_i;
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // The ceiling is several times the length of the directed run.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 500) begin
            errors++;
            give_verdict();
        end
    end
    task automatic check(input slw_data_t seen, input slw_data_t exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic a, input logic w, input slw_lanes_t l, input slw_addr_t ad,
                       input slw_data_t d, input int k, input slw_data_t e, input logic [4:0] c);
        @(negedge clk_i);
        if (pk[1] == 1) check(dq_out, pe[1]);
        if (pk[1] != 0) check(dq_oe, pk[1] == 1);
        pk[1] = pk[0];
        pe[1] = pe[0];
        pk[0] = k;
        pe[0] = e;
        advance_load   = a;
        wn    = w;
        lanes = l;
        addr  = ad;
        wdata = d;
        send  = !w;
        ctl   = c;
    endtask
    task automatic test_reset();
        check(dq_oe, 1'b0);
        check(eck_oe, 1'b0);
    endtask
    task automatic test_primary();
        cmd(1'b0, 1'b1, 4'h0, ad_a, '0, 2, '0, 5'h10);
        repeat (2) cmd(1'b1, 1'b1, 4'h0, ad_a, '0, 2, '0, 5'h10);
        check(eck_oe, 1'b1);
    endtask
    task automatic test_lanes();
        cmd(1'b0, 1'b0, 4'h0, ad_a, 36'h1_2345_6789, 2, '0, on);
        cmd(1'b0, 1'b0, 4'hE, ad_a, 36'hF_FFFF_FFFF, 2, '0, on);
        cmd(1'b0, 1'b0, 4'hF, ad_a, '0, 2, '0, on);
        cmd(1'b0, 1'b0, 4'h7, ad_a, '0, 2, '0, on);
        cmd(1'b0, 1'b1, 4'h0, ad_a, '0, 1, d_a, on);
        cmd(1'b0, 1'b1, 4'hF, ad_a, '0, 1, d_a, on);
    endtask
    task automatic test_burst();
        cmd(1'b0, 1'b0, 4'h0, ad_b - 19'h0_0002, d_p, 2, '0, on);
        for (int k = 0; k < 5; k++) begin
            cmd(k != 0, 1'b0, k == 2 ? 4'hF : 4'h0, k != 0 ? ~ad_b : ad_b,
                36'hA_0000_0000 + 36'(k), 2, '0, on);
        end
        for (int k = 0; k < 5; k++) begin
            cmd(k != 0, 1'b1, 4'h0, k != 0 ? ~ad_b : ad_b, '0, 1, k == 2 ? d_p :
                36'hA_0000_0000 + 36'(k % 4 == 0 ? 4 : k), on);
        end
    endtask
    task automatic test_straps();
        for (int s = 0; s < 4; s++) begin
            cmd(1'b0, 1'b1, 4'h0, ad_a, '0, 1, d_a, {1'b0, 2'(s), 2'(s)});
            cmd(1'b0, 1'b1, 4'h0, ad_a, '0, 2, '0, {1'b0, 2'(s), 2'(s) ^ 2'h1});
            cmd(1'b1, 1'b1, 4'h0, ad_a, '0, 2, '0, {1'b0, 2'(s), 2'(s) ^ 2'h1});
            dstrap = s[0];
            cmd(1'b0, 1'b1, 4'h0, ad_a, '0, 2, '0, {1'b0, 2'(s), 2'(s) ^ 2'h2});
            check(eck_oe, 1'b0);
            check(hdrv, !dstrap);
        end
    endtask
    initial begin
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        test_reset();
        test_primary();
        test_lanes();
        test_burst();
        test_straps();
        repeat (2) cmd(1'b0, 1'b1, 4'h0, ad_a, '0, 2, '0, 5'h10);
        give_verdict();
    end
endmodule
